/* File: include/ptr_regs.vh */
// Constants for the PWM, timer and converter trigger routing block
`ifndef PTR_REGS_VH
`define PTR_REGS_VH

// ----------------------------------------------------------------------
// Routing selection bit positions
// ----------------------------------------------------------------------
`define PTR_SEL_RELOAD_TO_CH3   0
`define PTR_SEL_CH3_TO_MASTER   1
`define PTR_SEL_CH2_TO_SECOND   2
`define PTR_SEL_LIMITS_TO_PWM   3
`define PTR_SEL_TIMER_TO_PWM    4
`define PTR_SEL_GPIO_TO_PWM     5
`define PTR_SEL_WIDTH           6
`define PTR_SEL_RESET           6'h00

// ----------------------------------------------------------------------
// Converter operating modes
// ----------------------------------------------------------------------
`define PTR_MODE_WIDTH          2
`define PTR_MODE_SEQUENTIAL     2'h0
`define PTR_MODE_PARALLEL       2'h1
`define PTR_MODE_PAR_INDEP      2'h2

// ----------------------------------------------------------------------
// PWM control source widths
// ----------------------------------------------------------------------
`define PTR_PWM_CTRL_WIDTH      4
`define PTR_GPIO_WIDTH          4
`define PTR_TIMER_WIDTH         4

`endif

/* File: src/ptr_edge.v */
// Rising edge detector giving one pulse per source pulse
`timescale 1ns/10ps
`default_nettype none

module ptr_edge (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Level in, pulse out
  input  wire level_in,
  output reg  pulse_q
);

  reg prev_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      prev_q  <= level_in;
      pulse_q <= level_in & ~prev_q;
    end
  end

endmodule // ptr_edge

`default_nettype wire

/* File: src/ptr_router.v */
// Trigger and protection routing between PWM, timer A and converters
`timescale 1ns/10ps
`default_nettype none
`include "ptr_regs.vh"

module ptr_router (
  // Clock and reset
  input  wire                          clk,
  input  wire                          rst,
  // Selection and mode from the system integration module
  input  wire [`PTR_SEL_WIDTH-1:0]     route_sel,
  input  wire [`PTR_MODE_WIDTH-1:0]    converter_mode,
  // PWM generator
  input  wire                          pwm_reload_pulse,
  output reg  [`PTR_PWM_CTRL_WIDTH-1:0] pwm_ctrl_q,
  // Timer module A
  input  wire                          timer_module_a_ch2_out,
  input  wire                          timer_module_a_ch3_out,
  output reg                           timer_module_a_ch3_in_q,
  input  wire [`PTR_TIMER_WIDTH-1:0]   timer_pwm_src,
  // GPIO pins (asynchronous)
  input  wire [`PTR_GPIO_WIDTH-1:0]    gpio_pwm_src,
  // Converters
  input  wire                          converter_a_over,
  input  wire                          converter_a_under,
  input  wire                          converter_b_over,
  input  wire                          converter_b_under,
  output reg                           converter_master_trigger_q,
  output reg                           converter_second_trigger_q,
  output reg                           converter_a_start_q,
  output reg                           converter_b_start_q
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function sel_bit;
    input [`PTR_SEL_WIDTH-1:0] sel;
    input integer              pos;
    begin
      sel_bit = sel[pos];
    end
  endfunction

  function [`PTR_PWM_CTRL_WIDTH-1:0] gate_vec;
    input                           en;
    input [`PTR_PWM_CTRL_WIDTH-1:0] vec;
    begin
      gate_vec = {`PTR_PWM_CTRL_WIDTH{en}} & vec;
    end
  endfunction

  // ----------------------------------------------------------------------
  // GPIO synchroniser
  // ----------------------------------------------------------------------
  // First stage feeds only the second stage
  reg [`PTR_GPIO_WIDTH-1:0] gpio_meta_q;
  reg [`PTR_GPIO_WIDTH-1:0] gpio_sync_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gpio_meta_q <= {`PTR_GPIO_WIDTH{1'b0}};
      gpio_sync_q <= {`PTR_GPIO_WIDTH{1'b0}};
    end else begin
      gpio_meta_q <= gpio_pwm_src;
      gpio_sync_q <= gpio_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger edge detection
  // ----------------------------------------------------------------------
  // Edges, not levels, so a long source high cannot give repeat starts
  wire ch3_pulse;
  wire ch2_pulse;

  ptr_edge u_edge_ch3 (
    .clk      (clk),
    .rst      (rst),
    .level_in (timer_module_a_ch3_out),
    .pulse_q  (ch3_pulse)
  );

  ptr_edge u_edge_ch2 (
    .clk      (clk),
    .rst      (rst),
    .level_in (timer_module_a_ch2_out),
    .pulse_q  (ch2_pulse)
  );

  // ----------------------------------------------------------------------
  // Routing decode
  // ----------------------------------------------------------------------
  wire en_reload = sel_bit(route_sel, `PTR_SEL_RELOAD_TO_CH3);
  wire en_master = sel_bit(route_sel, `PTR_SEL_CH3_TO_MASTER);
  wire en_second = sel_bit(route_sel, `PTR_SEL_CH2_TO_SECOND);
  wire en_limits = sel_bit(route_sel, `PTR_SEL_LIMITS_TO_PWM);
  wire en_timer  = sel_bit(route_sel, `PTR_SEL_TIMER_TO_PWM);
  wire en_gpio   = sel_bit(route_sel, `PTR_SEL_GPIO_TO_PWM);

  // Unknown mode code starts nothing
  reg mode_joint;
  reg mode_indep;

  always @* begin
    mode_joint = 1'b0;
    mode_indep = 1'b0;
    case (converter_mode)
      `PTR_MODE_SEQUENTIAL: mode_joint = 1'b1;
      `PTR_MODE_PARALLEL:   mode_joint = 1'b1;
      `PTR_MODE_PAR_INDEP:  mode_indep = 1'b1;
      default:              mode_joint = 1'b0;
    endcase
  end

  wire master_d = en_master & ch3_pulse;
  wire second_d = en_second & ch2_pulse;

  // ----------------------------------------------------------------------
  // PWM control sources
  // ----------------------------------------------------------------------
  // Limits are OR-ed across both converters: either one may stop the PWM
  wire over_any;
  wire under_any;

  assign over_any  = converter_a_over | converter_b_over;
  assign under_any = converter_a_under | converter_b_under;

  wire [`PTR_PWM_CTRL_WIDTH-1:0] limit_vec;
  assign limit_vec = {2'h0, under_any, over_any};

  reg  [`PTR_PWM_CTRL_WIDTH-1:0] pwm_ctrl_d;

  // GPIO part lags two cycles behind the others through the synchroniser
  always @* begin
    pwm_ctrl_d = gate_vec(en_limits, limit_vec);
    pwm_ctrl_d = pwm_ctrl_d | gate_vec(en_timer, timer_pwm_src);
    pwm_ctrl_d = pwm_ctrl_d | gate_vec(en_gpio, gpio_sync_q);
  end

  // ----------------------------------------------------------------------
  // Reload path into timer module A channel 3
  // ----------------------------------------------------------------------
  // No edge detector: the reload is already a one-cycle pulse on this clock
  reg ch3_in_d;

  always @* begin
    ch3_in_d = en_reload & pwm_reload_pulse;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_module_a_ch3_in_q <= 1'b0;
    end else begin
      timer_module_a_ch3_in_q <= ch3_in_d;
    end
  end

  // ----------------------------------------------------------------------
  // Converter trigger outputs
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_master_trigger_q <= 1'b0;
      converter_second_trigger_q <= 1'b0;
    end else begin
      converter_master_trigger_q <= master_d;
      converter_second_trigger_q <= second_d;
    end
  end

  // ----------------------------------------------------------------------
  // Converter start outputs
  // ----------------------------------------------------------------------
  // In independent mode the master starts converter A alone
  reg a_start_d;
  reg b_start_d;

  always @* begin
    a_start_d = master_d & (mode_joint | mode_indep);
    b_start_d = 1'b0;
    if (mode_joint) begin
      b_start_d = master_d;
    end else if (mode_indep) begin
      b_start_d = second_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_a_start_q <= 1'b0;
      converter_b_start_q <= 1'b0;
    end else begin
      converter_a_start_q <= a_start_d;
      converter_b_start_q <= b_start_d;
    end
  end

  // ----------------------------------------------------------------------
  // PWM control output
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_ctrl_q <= {`PTR_PWM_CTRL_WIDTH{1'b0}};
    end else begin
      pwm_ctrl_q <= pwm_ctrl_d;
    end
  end

endmodule // ptr_router

`default_nettype wire

/* File: src/ptr_router_unused_guard.v */
// Compilation unit without logic, holds only the time scale
`timescale 1ns/10ps

/* File: testbench/ptr_router_assertions.sv */
// Concurrent checks on the trigger and protection router ports
`timescale 1ns/10ps
`default_nettype none
`include "ptr_regs.vh"
module ptr_router_assertions (
  // Clock, reset and selection
  input wire logic       clk, rst,
  input wire logic [5:0] route_sel,
  input wire logic [1:0] converter_mode,
  // Sources
  input wire logic       pwm_reload_pulse, timer_module_a_ch2_out, timer_module_a_ch3_out,
  input wire logic       converter_a_over, converter_a_under, converter_b_over, converter_b_under,
  input wire logic [3:0] timer_pwm_src, gpio_pwm_src,
  // Routed outputs
  input wire logic       timer_module_a_ch3_in_q, converter_master_trigger_q,
  input wire logic       converter_second_trigger_q, converter_a_start_q, converter_b_start_q,
  input wire logic [3:0] pwm_ctrl_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_reload_path: assert property (
    pwm_reload_pulse && route_sel[0] |=> timer_module_a_ch3_in_q) else $error("reload lost");
  chk_reload_off: assert property (
    !(pwm_reload_pulse && route_sel[0]) |=> !timer_module_a_ch3_in_q) else $error("stray ch3 in");
  chk_master_path: assert property (
    $rose(timer_module_a_ch3_out) && route_sel[1] ##2 route_sel[1] |-> converter_master_trigger_q)
    else $error("master trigger lost");
  chk_second_path: assert property (
    $rose(timer_module_a_ch2_out) && route_sel[2] ##2 route_sel[2] |-> converter_second_trigger_q)
    else $error("second trigger lost");
  chk_start_both: assert property (
    converter_master_trigger_q && converter_mode < 2'h2 |-> converter_a_start_q && converter_b_start_q)
    else $error("joint start missing");
  chk_indep_b: assert property (
    converter_mode == `PTR_MODE_PAR_INDEP |-> converter_b_start_q == converter_second_trigger_q)
    else $error("independent start wrong");
  chk_limit_ctrl: assert property (
    route_sel[5:3] == 3'h1 && converter_b_under |=> pwm_ctrl_q[1]) else $error("limit not routed");
  chk_timer_ctrl: assert property (
    route_sel[4] && timer_pwm_src[2] |=> pwm_ctrl_q[2]) else $error("timer not routed");
  chk_idle_ctrl: assert property (
    (route_sel[5:3] == 3'h0) [*4] |=> pwm_ctrl_q == 4'h0) else $error("pwm control leak");
endmodule // ptr_router_assertions
`default_nettype wire

/* File: testbench/ptr_far_end.sv */
// Far-end model: PWM generator, timer A channels and converters
`timescale 1ns/10ps
`default_nettype none
module ptr_far_end (
  // Clock and enable
  input wire logic      clk, en,
  // Sources toward the router
  output var logic      pwm_reload_pulse, timer_module_a_ch2_out, timer_module_a_ch3_out,
  output var logic      converter_a_over, converter_a_under, converter_b_over, converter_b_under,
  output var logic [3:0] timer_pwm_src, gpio_pwm_src
);
  initial {pwm_reload_pulse, timer_module_a_ch2_out, timer_module_a_ch3_out} = 3'h0;
  // Channel highs last one cycle so rises are at least two cycles apart
  always @(posedge clk) begin
    pwm_reload_pulse <= en && $urandom_range(2) == 0;
    timer_module_a_ch3_out <= en && !timer_module_a_ch3_out && $urandom_range(1);
    timer_module_a_ch2_out <= en && !timer_module_a_ch2_out && $urandom_range(1);
    {converter_a_over, converter_a_under, converter_b_over, converter_b_under} <= 4'($urandom);
    {timer_pwm_src, gpio_pwm_src} <= 8'($urandom);
  end
endmodule // ptr_far_end
`default_nettype wire

/* File: testbench/tb_top.sv */
// Top testbench for the trigger and protection router
`timescale 1ns/10ps
`default_nettype none
`include "ptr_regs.vh"
module tb_top;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, p2 = 1'b0, p3 = 1'b0;
  logic [5:0] route_sel = 6'h00;
  logic [1:0] converter_mode = 2'h0;
  logic pwm_reload_pulse, timer_module_a_ch2_out, timer_module_a_ch3_out, timer_module_a_ch3_in_q;
  logic converter_a_over, converter_a_under, converter_b_over, converter_b_under;
  logic converter_master_trigger_q, converter_second_trigger_q, converter_a_start_q, converter_b_start_q;
  logic [3:0] timer_pwm_src, gpio_pwm_src, pwm_ctrl_q;
  logic [15:0] mismatches = 16'h0, checks = 16'h0, n_rl, n_m, n_s, o_rl, o_m, o_s, o_a, o_b;
  ptr_router u_ptr_router (.*);
  ptr_far_end u_ptr_far_end (.*);
  initial forever #4 clk = ~clk;
  // ----
  // Pulse counting
  // ----
  always @(posedge clk) begin
    p2 <= timer_module_a_ch2_out;
    p3 <= timer_module_a_ch3_out;
    n_rl += pwm_reload_pulse & route_sel[0];
    n_m += timer_module_a_ch3_out & !p3 & route_sel[1];
    n_s += timer_module_a_ch2_out & !p2 & route_sel[2];
    o_rl += timer_module_a_ch3_in_q;
    o_m += converter_master_trigger_q;
    o_s += converter_second_trigger_q;
    o_a += converter_a_start_q;
    o_b += converter_b_start_q;
  end
  // PWM control model: limits and timer one cycle late, GPIO three
  logic [3:0] g1, g2, e_lt, e_g;
  logic [2:0] warm = 3'h0;
  always @(posedge clk) begin
    g1 <= gpio_pwm_src;
    g2 <= g1;
    e_lt <= ({4{route_sel[3]}} & {2'h0, converter_a_under | converter_b_under,
             converter_a_over | converter_b_over}) | ({4{route_sel[4]}} & timer_pwm_src);
    e_g <= {4{route_sel[5]}} & g2;
    warm <= rst ? 3'h0 : (warm == 3'h4) ? warm : warm + 3'h1;
    if (warm == 3'h4) cmp("pwm_ctrl", {12'h0, e_lt | e_g}, {12'h0, pwm_ctrl_q});
  end
  function automatic logic [15:0] want(input logic [1:0] m, input logic b, input logic [15:0] nm, ns);
    if (m == `PTR_MODE_PAR_INDEP) return b ? ns : nm;
    return (m == 2'h3) ? 16'h0 : nm;
  endfunction
  task automatic cmp(input string what, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 16'h0 && checks != 16'h0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h65AC));
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    // All paths on for every mode, then all off, then random selections
    for (int i = 0; i < 12; i++) begin
      route_sel = (i < 4) ? 6'h3F : (i == 4) ? 6'h00 : 6'($urandom);
      converter_mode = 2'(i);
      {n_rl, n_m, n_s, o_rl, o_m, o_s, o_a, o_b} = '0;
      en = 1'b1;
      repeat (200) @(posedge clk);
      #1 en = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      cmp("reload_to_ch3", n_rl, o_rl);
      cmp("master_trigger", n_m, o_m);
      cmp("second_trigger", n_s, o_s);
      cmp("start_a", want(converter_mode, 1'b0, n_m, n_s), o_a);
      cmp("start_b", want(converter_mode, 1'b1, n_m, n_s), o_b);
      $display("test %0d done sel %h mode %0d", i, route_sel, converter_mode);
    end
    complete_run();
  end
endmodule // tb_top
bind ptr_router ptr_router_assertions u_ptr_router_assertions (.*);
`default_nettype wire
